/* rtsr_cfg.svh */
/*
 * Register map, field positions, reset values and frame constants for the
 * radio tuning and status register bank.
 * Assumes it is included by bare name by the files that need it.
 */
`ifndef RTSR_CFG_SVH
`define RTSR_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RTSR_ADDR_W             6
`define RTSR_ADDR_STRENGTH      6'h22
`define RTSR_ADDR_TX_POWER      6'h23
`define RTSR_ADDR_XTAL_TRIM     6'h24
`define RTSR_ADDR_OSC_SLOPE     6'h26

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define RTSR_STRENGTH_W         5
`define RTSR_PA_W               3
`define RTSR_TRIM_W             6
`define RTSR_SLOPE_W            2
`define RTSR_CLKOUT_DIS_BIT     6
`define RTSR_SLOPE_LSB          6
`define RTSR_CMD_WRITE_BIT      7
`define RTSR_RSVD_STRENGTH      2'h0

// ----------------------------------------------------------------------
// Reset values and frame constants
// ----------------------------------------------------------------------
`define RTSR_BYTE_RST           8'h00
`define RTSR_PA_RST             3'h0
`define RTSR_TRIM_RST           6'h00
`define RTSR_STRENGTH_RST       5'h00
`define RTSR_BIT_LAST           3'h7
`define RTSR_BIT_FIRST          3'h0
`define RTSR_ADDR_STEP          6'h01

`endif

/* rtsr_host_model.sv */
/* Host controller model for the serial port, mode 0, MSB first.
   Assumes the bench resolves the data-out line and calls these tasks. */
`timescale 1ns/1ps
module rtsr_host_model (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // Ten clocks a half period leaves margin over the eight-clock minimum
    localparam int HALF = 10;
    // Non-blocking here too, so each pin has a single assignment style
    initial begin
        spi_sck  <= 1'b0;
        spi_cs_n <= 1'b1;
        spi_mosi <= 1'b0;
    end
    task automatic select();
        @(posedge mclk);
        spi_cs_n <= 1'b0;
        repeat (HALF) @(posedge mclk);
    endtask
    // Release flips data in, so a held level never poses as a bit
    task automatic release_bus();
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (HALF) @(posedge mclk);
    endtask
    // Data in changes with the low phase; data out is taken as sck rises
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi <= tx[i];
            repeat (HALF) @(posedge mclk);
            spi_sck <= 1'b1;
            rx[i] = spi_miso;
            repeat (HALF) @(posedge mclk);
            spi_sck <= 1'b0;
        end
    endtask
    task automatic wr(input logic [5:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        select();
        xfer({2'h2, addr}, rx);
        xfer(data, rx);
        release_bus();
    endtask
    task automatic rd(input logic [5:0] addr, output logic [7:0] data);
        logic [7:0] rx;
        select();
        xfer({2'h0, addr}, rx);
        xfer(8'h00, data);
        release_bus();
    endtask
    // Start-up burst: full bias, clock output off, wide slope
    task automatic init_burst(input logic [5:0] trim);
        logic [7:0] rx;
        select();
        xfer(8'hA3, rx);
        xfer(8'h07, rx);
        xfer({2'h1, trim}, rx);
        xfer(8'h00, rx); // Unused slot between trim and slope
        xfer(8'hC0, rx);
        release_bus();
    endtask
endmodule

/* rtsr_pkg.sv */
/*
 * Types shared by the radio tuning and status register bank.
 * Assumes rtsr_cfg.svh supplies the widths.
 */
`include "rtsr_cfg.svh"

package rtsr_pkg;

    // ------------------------------------------------------------------
    // Serial frame state, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_CMD  = 3'b010,
        SPI_DATA = 3'b100
    } rtsr_spi_state_t;

    // ------------------------------------------------------------------
    // Oscillator slope codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLOPE_OFF  = 2'b00,
        SLOPE_RSVD = 2'b01,
        SLOPE_2_3  = 2'b10,
        SLOPE_5_5  = 2'b11
    } rtsr_slope_t;

    // ------------------------------------------------------------------
    // Settings handed to the analog side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`RTSR_PA_W-1:0]   pa_bias;
        logic                    clkout_disable;
        logic [`RTSR_TRIM_W-1:0] xtal_trim;
        rtsr_slope_t             slope;
    } rtsr_cfg_t;

    // Decoded slope adjust request
    typedef struct packed {
        logic adjust_en;
        logic wide_range;
    } rtsr_slope_ctl_t;

endpackage

/* rtsr_regs.sv */
/*
 * Radio tuning and status register bank behind a serial peripheral port.
 * Assumes a mode-0 host (sample on rising clock, shift on falling), serial
 * clock well below mclk/8, and receive-mode and strength inputs on mclk.
 */
//
// Behaviour
// - Strength register read-only, top two bits reserved
// - Bit five flags strength measurement valid
// - Five-bit unsigned strength, higher means stronger
// - One strength sample per entry into receive
// - Three-bit amplifier bias, higher code more power
// - Trim bit six stops reference clock output
// - Low six trim bits set oscillator load
// - Slope codes: wide, narrow, reserved, off
// - Slope field write-only, read value undefined
`timescale 1ns/1ps
`include "rtsr_cfg.svh"

module rtsr_regs
    import rtsr_pkg::*;
(
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // Serial peripheral pins
    input  wire logic                        spi_sck,
    input  wire logic                        spi_cs_n,
    input  wire logic                        spi_mosi,
    output logic                             spi_miso_o,
    output logic                             spi_miso_oe,
    // Receive path status
    input  wire logic                        rx_mode,
    input  wire logic                        strength_ready,
    input  wire logic [`RTSR_STRENGTH_W-1:0] strength_sample,
    // Settings to the analog side
    output rtsr_cfg_t                        cfg,
    output rtsr_slope_ctl_t                  slope_ctl,
    output logic                             reference_clock_output_pin_en
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic sck_s;
    logic cs_n_s;
    logic mosi_s;

    rtsr_sync #(
        .W       (3),
        .RST_VAL (3'b010)
    ) u_sync (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .pin_in    ({spi_sck, spi_cs_n, spi_mosi}),
        .level_out ({sck_s, cs_n_s, mosi_s})
    );

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    rtsr_spi_state_t         st_r, st_nxt;
    logic                    sck_d_r, sck_d_nxt;
    logic [2:0]              bit_r, bit_nxt;
    logic [7:0]              rx_sh_r, rx_sh_nxt;
    logic [7:0]              tx_sh_r, tx_sh_nxt;
    logic [`RTSR_ADDR_W-1:0] addr_r, addr_nxt;
    logic                    wr_r, wr_nxt;
    logic                    miso_r, miso_nxt;
    logic                    oe_r, oe_nxt;
    logic                    sck_rise;
    logic                    sck_fall;
    logic [7:0]              rx_byte;
    logic                    wr_stb;
    logic [`RTSR_ADDR_W-1:0] wr_addr;
    logic [7:0]              wr_data;

    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign rx_byte  = {rx_sh_r[6:0], mosi_s};

    // Read mux, also used to preload the shifter for burst reads
    function automatic logic [7:0] rd_mux(input logic [`RTSR_ADDR_W-1:0] a,
                                          input logic [7:0] strength_byte,
                                          input rtsr_cfg_t c);
        logic [7:0] v;
        v = `RTSR_BYTE_RST;
        case (a)
            `RTSR_ADDR_STRENGTH:  v = strength_byte;
            `RTSR_ADDR_TX_POWER:  v = {5'h00, c.pa_bias};
            `RTSR_ADDR_XTAL_TRIM: v = {1'b0, c.clkout_disable, c.xtal_trim};
            `RTSR_ADDR_OSC_SLOPE: v = `RTSR_BYTE_RST;
            default:              v = `RTSR_BYTE_RST;
        endcase
        return v;
    endfunction

    logic [7:0] strength_byte;
    rtsr_cfg_t  cfg_r;

    // Command byte: write flag, reserved bit, address; then data bytes
    always_comb begin
        st_nxt    = st_r;
        sck_d_nxt = sck_s;
        bit_nxt   = bit_r;
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        addr_nxt  = addr_r;
        wr_nxt    = wr_r;
        miso_nxt  = miso_r;
        oe_nxt    = ~cs_n_s;
        wr_stb    = 1'b0;
        wr_addr   = addr_r;
        wr_data   = rx_byte;
        case (st_r)
            SPI_IDLE: begin
                bit_nxt  = `RTSR_BIT_FIRST;
                miso_nxt = 1'b0;
                if (!cs_n_s) begin
                    st_nxt = SPI_CMD;
                end
            end
            SPI_CMD: begin
                if (sck_rise) begin
                    rx_sh_nxt = rx_byte;
                    bit_nxt   = bit_r + 3'h1;
                    if (bit_r == `RTSR_BIT_LAST) begin
                        wr_nxt    = rx_byte[`RTSR_CMD_WRITE_BIT];
                        addr_nxt  = rx_byte[`RTSR_ADDR_W-1:0];
                        tx_sh_nxt = rd_mux(rx_byte[`RTSR_ADDR_W-1:0], strength_byte,
                                           cfg_r);
                        st_nxt    = SPI_DATA;
                    end
                end
            end
            SPI_DATA: begin
                if (sck_fall) begin
                    miso_nxt  = tx_sh_r[7];
                    tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
                end
                if (sck_rise) begin
                    rx_sh_nxt = rx_byte;
                    bit_nxt   = bit_r + 3'h1;
                    if (bit_r == `RTSR_BIT_LAST) begin
                        // Byte complete: commit, then step for bursts
                        wr_stb    = wr_r;
                        addr_nxt  = addr_r + `RTSR_ADDR_STEP;
                        tx_sh_nxt = rd_mux(addr_r + `RTSR_ADDR_STEP, strength_byte,
                                           cfg_r);
                    end
                end
            end
            default: begin
                st_nxt = SPI_IDLE;
            end
        endcase
        // Deselect aborts any partial byte; it is never committed
        if (cs_n_s) begin
            st_nxt = SPI_IDLE;
            wr_stb = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r    <= SPI_IDLE;
            sck_d_r <= 1'b0;
            bit_r   <= `RTSR_BIT_FIRST;
            rx_sh_r <= `RTSR_BYTE_RST;
            tx_sh_r <= `RTSR_BYTE_RST;
            addr_r  <= '0;
            wr_r    <= 1'b0;
            miso_r  <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            sck_d_r <= sck_d_nxt;
            bit_r   <= bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            addr_r  <= addr_nxt;
            wr_r    <= wr_nxt;
            miso_r  <= miso_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------------
    rtsr_cfg_t       cfg_nxt;
    rtsr_slope_ctl_t slope_r, slope_nxt;
    logic            clk_en_r, clk_en_nxt;

    // Reserved bits are dropped on write, so they always read back zero
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_stb) begin
            case (wr_addr)
                `RTSR_ADDR_TX_POWER: begin
                    cfg_nxt.pa_bias = wr_data[`RTSR_PA_W-1:0];
                end
                `RTSR_ADDR_XTAL_TRIM: begin
                    cfg_nxt.clkout_disable = wr_data[`RTSR_CLKOUT_DIS_BIT];
                    cfg_nxt.xtal_trim      = wr_data[`RTSR_TRIM_W-1:0];
                end
                `RTSR_ADDR_OSC_SLOPE: begin
                    cfg_nxt.slope = rtsr_slope_t'(
                        wr_data[`RTSR_SLOPE_LSB +: `RTSR_SLOPE_W]);
                end
                default: begin
                    cfg_nxt = cfg_r;
                end
            endcase
        end
        // Decode follows the stored code; the reserved code adjusts nothing
        case (cfg_nxt.slope)
            SLOPE_5_5: slope_nxt = '{adjust_en: 1'b1, wide_range: 1'b1};
            SLOPE_2_3: slope_nxt = '{adjust_en: 1'b1, wide_range: 1'b0};
            default:   slope_nxt = '{adjust_en: 1'b0, wide_range: 1'b0};
        endcase
        clk_en_nxt = ~cfg_nxt.clkout_disable;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r    <= '{pa_bias: `RTSR_PA_RST, clkout_disable: 1'b0,
                          xtal_trim: `RTSR_TRIM_RST, slope: SLOPE_OFF};
            slope_r  <= '{adjust_en: 1'b0, wide_range: 1'b0};
            clk_en_r <= 1'b1;
        end else begin
            cfg_r    <= cfg_nxt;
            slope_r  <= slope_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Signal strength capture
    // ------------------------------------------------------------------
    logic                        rx_d_r, rx_d_nxt;
    logic                        armed_r, armed_nxt;
    logic                        valid_r, valid_nxt;
    logic [`RTSR_STRENGTH_W-1:0] value_r, value_nxt;

    // Entering receive arms one capture and drops the old result; the
    // first sample after that is kept until the next entry into receive
    always_comb begin
        rx_d_nxt  = rx_mode;
        armed_nxt = armed_r;
        valid_nxt = valid_r;
        value_nxt = value_r;
        if (rx_mode && !rx_d_r) begin
            armed_nxt = 1'b1;
            valid_nxt = 1'b0;
        end else if (armed_r && rx_mode && strength_ready) begin
            armed_nxt = 1'b0;
            valid_nxt = 1'b1;
            value_nxt = strength_sample;
        end
        if (!rx_mode) begin
            armed_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_d_r  <= 1'b0;
            armed_r <= 1'b0;
            valid_r <= 1'b0;
            value_r <= `RTSR_STRENGTH_RST;
        end else begin
            rx_d_r  <= rx_d_nxt;
            armed_r <= armed_nxt;
            valid_r <= valid_nxt;
            value_r <= value_nxt;
        end
    end

    // Reserved top bits read zero
    assign strength_byte = {`RTSR_RSVD_STRENGTH, valid_r, value_r};

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign spi_miso_o                    = miso_r;
    assign spi_miso_oe                   = oe_r;
    assign cfg                           = cfg_r;
    assign slope_ctl                     = slope_r;
    assign reference_clock_output_pin_en = clk_en_r;

endmodule

/* rtsr_regs_checker.sv */
/* Assertions on the tuning register bank ports.
   Assumes it is bound to rtsr_regs and sees only that module's ports. */
`timescale 1ns/1ps
`include "rtsr_cfg.svh"
module rtsr_regs_checker
    import rtsr_pkg::*;
(
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        sys_rst,
    // Serial pins
    input wire logic                        spi_sck,
    input wire logic                        spi_cs_n,
    input wire logic                        spi_mosi,
    input wire logic                        spi_miso_o,
    input wire logic                        spi_miso_oe,
    // Receive status
    input wire logic                        rx_mode,
    input wire logic                        strength_ready,
    input wire logic [`RTSR_STRENGTH_W-1:0] strength_sample,
    // Settings
    input wire rtsr_cfg_t                   cfg,
    input wire rtsr_slope_ctl_t             slope_ctl,
    input wire logic                        reference_clock_output_pin_en
);
    // ----
    // Clocks since chip select went high, saturating at 15
    // ----
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    always_comb begin
        idle_nxt = (idle_r == 4'hF) ? idle_r : idle_r + 4'h1;
        if (!spi_cs_n) begin
            idle_nxt = 4'h0;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_r <= 4'h0;
        end else begin
            idle_r <= idle_nxt;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Eight clocks is past the synchroniser and output register delay
    sequence s_sel; !spi_cs_n [*8]; endsequence
    sequence s_desel; spi_cs_n [*8]; endsequence
    property p_refclk; reference_clock_output_pin_en == !cfg.clkout_disable; endproperty
    property p_slope; slope_ctl == {cfg.slope[1], cfg.slope == SLOPE_5_5}; endproperty
    property p_rst_cfg;
        $fell(sys_rst) |-> cfg == '0 && slope_ctl == '0 && reference_clock_output_pin_en;
    endproperty
    property p_rst_miso; $fell(sys_rst) |-> !spi_miso_oe && !spi_miso_o; endproperty
    property p_cfg_frame; !$stable(cfg) |-> idle_r < 4'hC; endproperty
    property p_rx_quiet; $rose(rx_mode) && idle_r > 4'h7 |=> $stable(cfg) [*4]; endproperty
    property p_oe_on; s_sel |-> spi_miso_oe; endproperty
    property p_oe_off; s_desel |-> !spi_miso_oe; endproperty
    a_refclk: assert property (p_refclk)
        else $error("clock pin enable disagrees with disable bit");
    a_slope: assert property (p_slope)
        else $error("slope decode wrong");
    a_rst_cfg: assert property (p_rst_cfg)
        else $error("settings not cleared by reset");
    a_rst_miso: assert property (p_rst_miso)
        else $error("data out driven after reset");
    a_cfg_frame: assert property (p_cfg_frame)
        else $error("settings changed outside a frame");
    a_rx_quiet: assert property (p_rx_quiet)
        else $error("receive entry disturbed settings");
    a_oe_on: assert property (p_oe_on)
        else $error("data out not driven while selected");
    a_oe_off: assert property (p_oe_off)
        else $error("data out driven while deselected");
endmodule

bind rtsr_regs rtsr_regs_checker u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .rx_mode(rx_mode), .strength_ready(strength_ready), .strength_sample(strength_sample),
    .cfg(cfg), .slope_ctl(slope_ctl),
    .reference_clock_output_pin_en(reference_clock_output_pin_en)
);

/* rtsr_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter, one lane per bit.
 * Assumes the inputs are asynchronous to mclk and change slowly against it.
 */
`timescale 1ns/1ps

module rtsr_sync #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);

    // ------------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic out_r;
            logic out_nxt;

            // Output moves only when stages two and three agree
            always_comb begin
                out_nxt = (s2_r == s3_r) ? s3_r : out_r;
            end

            // The first stage feeds the second and nothing else
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    s1_r  <= RST_VAL[g];
                    s2_r  <= RST_VAL[g];
                    s3_r  <= RST_VAL[g];
                    out_r <= RST_VAL[g];
                end else begin
                    s1_r  <= pin_in[g];
                    s2_r  <= s1_r;
                    s3_r  <= s2_r;
                    out_r <= out_nxt;
                end
            end

            assign level_out[g] = out_r;
        end
    endgenerate

endmodule

/* testbench.sv */
/* Self-checking bench for the tuning register bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`include "rtsr_cfg.svh"
module testbench;
    import rtsr_pkg::*;
    // ----
    // Stimulus, wires and counters
    // ----
    logic            mclk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            rx_mode = 1'b0;
    logic            strength_ready = 1'b0;
    logic [4:0]      strength_sample = 5'h00;
    logic            spi_sck;
    logic            spi_cs_n;
    logic            spi_mosi;
    logic            spi_miso_o;
    logic            spi_miso_oe;
    logic            idle_tgl = 1'b0;
    wire logic       miso_line;
    rtsr_cfg_t       cfg;
    rtsr_slope_ctl_t slope_ctl;
    logic            refclk_en;
    logic [7:0]      rd_byte;
    int              fail_count = 0;
    int              num_checks = 0;
    localparam logic [5:0] ADDRS [4] = '{6'h22, 6'h23, 6'h24, 6'h26};
    localparam logic [7:0] BURST [5] = '{8'h00, 8'h07, 8'h6A, 8'h00, 8'h00};
    always #25 mclk = ~mclk;
    // Undriven data out toggles so a stale level never reads as data
    always @(posedge mclk) idle_tgl <= ~idle_tgl;
    assign miso_line = spi_miso_oe ? spi_miso_o : idle_tgl;
    rtsr_host_model u_host (.mclk(mclk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(miso_line));
    rtsr_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
        .spi_miso_oe(spi_miso_oe), .rx_mode(rx_mode), .strength_ready(strength_ready),
        .strength_sample(strength_sample), .cfg(cfg), .slope_ctl(slope_ctl),
        .reference_clock_output_pin_en(refclk_en));
    // ----
    // Shared helpers
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Settings outputs, clock pin enable and slope decode in one comparison set
    task automatic check_cfg(input logic [11:0] exp);
        check({4'h0, cfg}, {4'h0, exp});
        check({15'h0, refclk_en}, {15'h0, ~exp[8]});
        check({14'h0, slope_ctl}, {14'h0, exp[1], exp[1:0] == 2'h3});
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset_values();
        check_cfg(12'h000);
        check({15'h0, spi_miso_oe}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            u_host.rd(ADDRS[k], rd_byte);
            check({8'h00, rd_byte}, 16'h0000);
        end
    endtask
    // Burst write across the unused slot, then burst read back
    task automatic t_init_burst();
        u_host.init_burst(6'h2A);
        check_cfg({3'h7, 1'h1, 6'h2A, 2'h3});
        u_host.select();
        u_host.xfer(8'h22, rd_byte);
        for (int k = 0; k < 5; k++) begin
            u_host.xfer(8'h00, rd_byte);
            check({8'h00, rd_byte}, {8'h00, BURST[k]});
        end
        u_host.release_bus();
    endtask
    task automatic t_codes();
        for (int c = 0; c < 4; c++) begin
            u_host.wr(6'h26, {c[1:0], 6'h00});
            check_cfg({3'h7, 1'h1, 6'h2A, c[1:0]});
            u_host.rd(6'h26, rd_byte);
            check({8'h00, rd_byte}, 16'h0000);
        end
        for (int p = 0; p < 8; p++) begin
            u_host.wr(6'h23, {5'h00, p[2:0]});
            u_host.rd(6'h23, rd_byte);
            check({8'h00, rd_byte}, {13'h0000, p[2:0]});
        end
        u_host.wr(6'h24, 8'h15);
        check_cfg({3'h7, 1'h0, 6'h15, 2'h3});
    endtask
    // Arming-cycle sample and a second sample must both be dropped
    task automatic t_strength();
        rx_mode <= 1'b1;
        strength_ready <= 1'b1;
        strength_sample <= 5'h11;
        tick(1);
        strength_ready <= 1'b0;
        tick(3);
        strength_ready <= 1'b1;
        strength_sample <= 5'h1F;
        tick(1);
        strength_sample <= 5'h03;
        tick(1);
        strength_ready <= 1'b0;
        u_host.rd(6'h22, rd_byte);
        check({8'h00, rd_byte}, 16'h003F);
        rx_mode <= 1'b0;
        tick(1);
        rx_mode <= 1'b1;
        tick(2);
        u_host.rd(6'h22, rd_byte);
        check({13'h0000, rd_byte[7:5]}, 16'h0000);
        strength_ready <= 1'b1;
        strength_sample <= 5'h04;
        tick(1);
        strength_ready <= 1'b0;
        rx_mode <= 1'b0;
        u_host.rd(6'h22, rd_byte);
        check({8'h00, rd_byte}, 16'h0024);
    endtask
    // Writes to the status register and to an unmapped place are ignored;
    // a sample offered outside receive mode must not be taken either
    task automatic t_refused();
        strength_ready  <= 1'b1;
        strength_sample <= 5'h1F;
        tick(1);
        strength_ready  <= 1'b0;
        u_host.wr(6'h22, 8'hFF);
        u_host.rd(6'h22, rd_byte);
        check({8'h00, rd_byte}, 16'h0024);
        u_host.wr(6'h30, 8'h5A);
        check_cfg({3'h7, 1'h0, 6'h15, 2'h3});
        u_host.rd(6'h30, rd_byte);
        check({8'h00, rd_byte}, 16'h0000);
    endtask
    task automatic t_mid_reset();
        sys_rst <= 1'b1;
        tick(5);
        sys_rst <= 1'b0;
        tick(2);
        check_cfg(12'h000);
        u_host.rd(6'h22, rd_byte);
        check({8'h00, rd_byte}, 16'h0000);
    endtask
    // ----
    // Main sequence and watchdog
    // ----
    initial begin
        tick(16);
        sys_rst <= 1'b0;
        tick(2);
        t_reset_values();
        t_init_burst();
        t_codes();
        t_strength();
        t_refused();
        t_mid_reset();
        test_done();
    end
    // About 40 frames of some 360 clocks each, with ample margin
    initial begin
        tick(60000);
        fail_count++;
        test_done();
    end
endmodule
